// ===== src/srrc_controller.sv
/*
 * Timing controller end: runs the per-row slave sequence over a frame
 * and holds the selects, under software control through a plain
 * register port.
 * Assumes the sensor answers each sampling start with sampling done.
 */
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "srrc_cfg.svh"

module srrc_controller
    import srrc_pkg::*;
#(
    parameter int COLS     = 1024,
    parameter int XFER_CYC = `SRRC_XFER_CYC
) (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    // Frame status
    output logic             o_busy,
    output logic             o_frame_done,
    // Link to sensor
    srrc_if.ctrl             lnk
);
    if (COLS < 4 || COLS > 65535 || XFER_CYC < 1 || XFER_CYC > 65535)
    begin : g_chk
        $error("srrc_controller: parameter out of range");
    end

    typedef struct packed {
        srrc_ctrl_st_e st;
        logic          auto_sw;
        logic [7:0]    cfg;
        logic [15:0]   rows;
        logic [15:0]   acc_rows;
        logic [15:0]   row_cnt;
        logic [15:0]   acc_cnt;
        logic          switched;
        logic [15:0]   tmr;
        logic          xfer_n;
        logic          samp_n;
        logic          go_n;
        logic          busy;
        logic          frame_done;
        logic [31:0]   rdata;
    } srrc_ctl_s;

    srrc_ctl_s st_ff;
    srrc_ctl_s nxt_st;
    logic [15:0] row_len;
    logic        sw_go;

    assign row_len = 16'(COLS) >> srrc_bin_shift(st_ff.cfg[`SRRC_CFG_CBIN +: 2]);
    assign sw_go   = i_wr && i_addr == `SRRC_REG_CTRL && i_wdata[`SRRC_CTRL_GO];

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.frame_done = 1'b0;
        nxt_st.rdata      = '0;

        if (i_wr) begin
            case (i_addr)
                `SRRC_REG_CTRL: nxt_st.auto_sw  = i_wdata[`SRRC_CTRL_AUTO];
                `SRRC_REG_CFG:  nxt_st.cfg      = i_wdata[7:0];
                `SRRC_REG_ROWS: nxt_st.rows     = i_wdata[15:0];
                `SRRC_REG_ACC:  nxt_st.acc_rows = i_wdata[15:0];
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `SRRC_REG_CTRL: nxt_st.rdata[`SRRC_CTRL_AUTO] = st_ff.auto_sw;
                `SRRC_REG_CFG:  nxt_st.rdata[7:0] = st_ff.cfg;
                `SRRC_REG_STAT: begin
                    nxt_st.rdata[`SRRC_STAT_BUSY]       = st_ff.busy;
                    nxt_st.rdata[`SRRC_STAT_STATE +: 3] = st_ff.st;
                    nxt_st.rdata[`SRRC_STAT_SWITCHED]   = st_ff.switched;
                    nxt_st.rdata[`SRRC_STAT_ROWS +: 16] = st_ff.row_cnt;
                end
                `SRRC_REG_ROWS: nxt_st.rdata[15:0] = st_ff.rows;
                `SRRC_REG_ACC:  nxt_st.rdata[15:0] = st_ff.acc_rows;
                default: ;
            endcase
        end

        // Strobes idle high; only the active step pulls one low
        nxt_st.xfer_n = 1'b1;
        nxt_st.samp_n = 1'b1;
        nxt_st.go_n   = 1'b1;
        case (st_ff.st)
            SRRC_C_IDLE: begin
                if (sw_go && i_wdata[15:0] != 16'h0000) begin
                    nxt_st.busy     = 1'b1;
                    nxt_st.row_cnt  = '0;
                    nxt_st.acc_cnt  = '0;
                    nxt_st.switched = 1'b0;
                    nxt_st.tmr      = 16'(XFER_CYC);
                    nxt_st.xfer_n   = 1'b0;
                    nxt_st.st       = SRRC_C_XFER;
                end
            end
            SRRC_C_XFER: begin
                if (st_ff.tmr > 16'h0001) begin
                    nxt_st.tmr    = st_ff.tmr - 16'h0001;
                    nxt_st.xfer_n = 1'b0;
                end else begin
                    nxt_st.samp_n = 1'b0;
                    nxt_st.st     = SRRC_C_SAMP;
                end
            end
            SRRC_C_SAMP: begin
                nxt_st.st = SRRC_C_WAIT;
            end
            SRRC_C_WAIT: begin
                if (!lnk.sampling_done_n) begin
                    nxt_st.go_n = 1'b0;
                    nxt_st.tmr  = row_len;
                    nxt_st.st   = SRRC_C_READ;
                end
            end
            SRRC_C_READ: begin
                if (st_ff.tmr > 16'h0001) begin
                    nxt_st.tmr = st_ff.tmr - 16'h0001;
                end else begin
                    nxt_st.row_cnt = st_ff.row_cnt + 16'h0001;
                    if (st_ff.cfg[`SRRC_CFG_MODE +: 2] == SRRC_MODE_ACCUM) begin
                        nxt_st.acc_cnt = st_ff.acc_cnt + 16'h0001;
                    end
                    if (st_ff.row_cnt + 16'h0001 >= st_ff.rows) begin
                        nxt_st.busy       = 1'b0;
                        nxt_st.frame_done = 1'b1;
                        nxt_st.st         = SRRC_C_IDLE;
                    end else begin
                        nxt_st.tmr    = 16'(XFER_CYC);
                        nxt_st.xfer_n = 1'b0;
                        nxt_st.st     = SRRC_C_XFER;
                    end
                end
            end
            default: begin
                nxt_st.st = SRRC_C_IDLE;
            end
        endcase

        // Hardware switch wins over a same-cycle software mode write
        if (st_ff.auto_sw && st_ff.acc_cnt >= st_ff.acc_rows
            && st_ff.cfg[`SRRC_CFG_MODE +: 2] == SRRC_MODE_ACCUM) begin
            nxt_st.cfg[`SRRC_CFG_MODE +: 2] = SRRC_MODE_READOUT_MODE_HI;
            nxt_st.switched                 = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_ff          <= '0;
            st_ff.st       <= SRRC_C_IDLE;
            st_ff.cfg      <= `SRRC_CFG_RST;
            st_ff.rows     <= `SRRC_ROWS_RST;
            st_ff.acc_rows <= `SRRC_ACC_RST;
            st_ff.xfer_n   <= 1'b1;
            st_ff.samp_n   <= 1'b1;
            st_ff.go_n     <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Selects are held from registers, never left undriven
    assign lnk.row_xfer_n       = st_ff.xfer_n;
    assign lnk.sampling_start_n = st_ff.samp_n;
    assign lnk.readout_go_n     = st_ff.go_n;
    assign lnk.video_source_sel = st_ff.cfg[`SRRC_CFG_VSRC];
    assign lnk.readout_mode_hi  = st_ff.cfg[`SRRC_CFG_MODE + 1];
    assign lnk.readout_mode_lo  = st_ff.cfg[`SRRC_CFG_MODE];
    assign lnk.column_bin_hi    = st_ff.cfg[`SRRC_CFG_CBIN + 1];
    assign lnk.column_bin_lo    = st_ff.cfg[`SRRC_CFG_CBIN];
    assign lnk.line_bin_hi      = st_ff.cfg[`SRRC_CFG_LBIN + 1];
    assign lnk.line_bin_lo      = st_ff.cfg[`SRRC_CFG_LBIN];
    assign o_rdata              = st_ff.rdata;
    assign o_busy               = st_ff.busy;
    assign o_frame_done         = st_ff.frame_done;
endmodule

`default_nettype wire

// ===== src/srrc_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * slave row readout control pair.
 * Assumes a 20 MHz clock and a byte-addressed register port.
 */
`ifndef SRRC_CFG_SVH
`define SRRC_CFG_SVH

`define SRRC_CLK_NS        50
`define SRRC_XFER_NS       200
`define SRRC_XFER_CYC      ((`SRRC_XFER_NS + `SRRC_CLK_NS - 1) / `SRRC_CLK_NS)
`define SRRC_CDS_NS        1000
`define SRRC_CDS_CYC       ((`SRRC_CDS_NS + `SRRC_CLK_NS - 1) / `SRRC_CLK_NS)

`define SRRC_REG_CTRL      8'h00
`define SRRC_REG_CFG       8'h04
`define SRRC_REG_STAT      8'h08
`define SRRC_REG_ROWS      8'h0C
`define SRRC_REG_ACC       8'h10

`define SRRC_CTRL_GO       0
`define SRRC_CTRL_AUTO     1
`define SRRC_CFG_MODE      0
`define SRRC_CFG_CBIN      2
`define SRRC_CFG_LBIN      4
`define SRRC_CFG_VSRC      6
`define SRRC_STAT_BUSY     0
`define SRRC_STAT_STATE    1
`define SRRC_STAT_SWITCHED 4
`define SRRC_STAT_ROWS     16

`define SRRC_CFG_RST       8'h00
`define SRRC_ROWS_RST      16'h0400
`define SRRC_ACC_RST       16'h0008

`endif

// ===== src/srrc_pkg.sv
/*
 * Types shared by both ends of the slave row readout control pair.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package srrc_pkg;

    typedef enum logic [1:0] {
        SRRC_MODE_STD   = 2'b00,
        SRRC_MODE_SNAP  = 2'b01,
        SRRC_MODE_ACCUM = 2'b10,
        SRRC_MODE_XRD   = 2'b11
    } srrc_mode_e;

    // Readout mode taken after accumulation is strong enough
    localparam srrc_mode_e SRRC_MODE_READOUT_MODE_HI = SRRC_MODE_SNAP;

    typedef enum logic [2:0] {
        SRRC_C_IDLE = 3'b000,
        SRRC_C_XFER = 3'b001,
        SRRC_C_SAMP = 3'b010,
        SRRC_C_WAIT = 3'b011,
        SRRC_C_READ = 3'b100
    } srrc_ctrl_st_e;

    typedef enum logic [1:0] {
        SRRC_D_IDLE = 2'b00,
        SRRC_D_CDS  = 2'b01,
        SRRC_D_DONE = 2'b10,
        SRRC_D_READ = 2'b11
    } srrc_dev_st_e;

    // Binning code: 00 1X, 01 2X, 1x 4X; result is a right shift
    function automatic logic [1:0] srrc_bin_shift(input logic [1:0] code);
        srrc_bin_shift = code[1] ? 2'h2 : {1'b0, code[0]};
    endfunction

endpackage

// ===== src/srrc_if.sv
/*
 * Slave-mode control lines between the timing controller and the sensor.
 * Assumes both ends share i_mclk; strobes are active low.
 */
`timescale 1ns/1ps
`default_nettype none

interface srrc_if;
    logic row_xfer_n;
    logic sampling_start_n;
    logic readout_go_n;
    logic sampling_done_n;
    logic video_source_sel;
    logic readout_mode_hi;
    logic readout_mode_lo;
    logic column_bin_hi;
    logic column_bin_lo;
    logic line_bin_hi;
    logic line_bin_lo;

    modport ctrl (
        output row_xfer_n, sampling_start_n, readout_go_n,
        output video_source_sel, readout_mode_hi, readout_mode_lo,
        output column_bin_hi, column_bin_lo, line_bin_hi, line_bin_lo,
        input  sampling_done_n
    );

    modport dev (
        input  row_xfer_n, sampling_start_n, readout_go_n,
        input  video_source_sel, readout_mode_hi, readout_mode_lo,
        input  column_bin_hi, column_bin_lo, line_bin_hi, line_bin_lo,
        output sampling_done_n
    );
endinterface

`default_nettype wire

// ===== src/srrc_cycle_timer.sv
/*
 * Down-counting cycle timer: load a count, busy while running,
 * one-cycle done pulse at the end.
 * Assumes i_count is at least one when loaded.
 */
`timescale 1ns/1ps
`default_nettype none

module srrc_cycle_timer
    import srrc_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    // Control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    // Status
    output logic              o_busy,
    output logic              o_done
);
    if (W < 2) begin : g_chk
        $error("srrc_cycle_timer: W below 2");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } srrc_tmr_s;

    srrc_tmr_s st_ff;
    srrc_tmr_s nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (i_load) begin
            nxt_st.cnt  = i_count;
            nxt_st.busy = 1'b1;
        end else if (st_ff.busy) begin
            if (st_ff.cnt <= W'(1)) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
                nxt_st.cnt  = '0;
            end else begin
                nxt_st.cnt = st_ff.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_busy = st_ff.busy;
    assign o_done = st_ff.done;
endmodule

`default_nettype wire

// ===== src/srrc_sensor.sv
/*
 * Sensor end in slave mode: charge move, sampling, readout of one row
 * and the static selects, reported to the pixel path as plain outputs.
 * Assumes the controller drives every slave-mode input synchronously.
 */
`timescale 1ns/1ps
`default_nettype none

`include "srrc_cfg.svh"

module srrc_sensor
    import srrc_pkg::*;
#(
    parameter int COLS    = 1024,
    parameter int CDS_CYC = `SRRC_CDS_CYC
) (
    // Clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_rst,
    // Link to controller
    srrc_if.dev        lnk,
    // Pixel path side
    output logic        o_charge_move,
    output logic        o_cds_busy,
    output logic        o_cds_applied,
    output logic        o_pixel_valid,
    output logic [15:0] o_pixel_idx,
    output logic        o_line_emit,
    output logic        o_video_ext,
    output srrc_mode_e  o_mode
);
    if (COLS < 4 || COLS > 65535 || CDS_CYC < 1 || CDS_CYC > 255)
    begin : g_chk
        $error("srrc_sensor: parameter out of range");
    end

    typedef struct packed {
        srrc_dev_st_e st;
        logic         done_n;
        logic         charge_move;
        logic         cds_applied;
        logic         pix_valid;
        logic [15:0]  pix_idx;
        logic [1:0]   line_cnt;
        logic         line_emit;
        logic         video_ext;
        srrc_mode_e   mode;
    } srrc_dev_s;

    srrc_dev_s st_ff;
    srrc_dev_s nxt_st;
    logic      tmr_load;
    logic      tmr_busy;
    logic      tmr_done;

    srrc_mode_e mode_in;
    logic [1:0] cshift;
    logic [1:0] lshift;
    logic [15:0] row_len;
    logic [1:0] line_last;

    assign mode_in   = srrc_mode_e'({lnk.readout_mode_hi, lnk.readout_mode_lo});
    assign cshift    = srrc_bin_shift({lnk.column_bin_hi, lnk.column_bin_lo});
    assign lshift    = srrc_bin_shift({lnk.line_bin_hi, lnk.line_bin_lo});
    assign row_len   = 16'(COLS) >> cshift;
    assign line_last = 2'((3'h1 << lshift) - 3'h1);

    srrc_cycle_timer #(.W(8)) u_cds_tmr (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_load  (tmr_load),
        .i_count (8'(CDS_CYC)),
        .o_busy  (tmr_busy),
        .o_done  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st             = st_ff;
        tmr_load           = 1'b0;
        nxt_st.line_emit   = 1'b0;
        nxt_st.charge_move = ~lnk.row_xfer_n;
        nxt_st.video_ext   = lnk.video_source_sel;
        nxt_st.mode        = mode_in;
        case (st_ff.st)
            SRRC_D_IDLE: begin
                if (!lnk.sampling_start_n) begin
                    if (mode_in == SRRC_MODE_ACCUM) begin
                        // No sampling pass, row is ready at once
                        nxt_st.cds_applied = 1'b0;
                        nxt_st.done_n      = 1'b0;
                        nxt_st.st          = SRRC_D_DONE;
                    end else begin
                        nxt_st.cds_applied = 1'b1;
                        tmr_load           = 1'b1;
                        nxt_st.st          = SRRC_D_CDS;
                    end
                end
            end
            SRRC_D_CDS: begin
                if (tmr_done) begin
                    nxt_st.done_n = 1'b0;
                    nxt_st.st     = SRRC_D_DONE;
                end
            end
            SRRC_D_DONE: begin
                if (!lnk.readout_go_n) begin
                    nxt_st.done_n    = 1'b1;
                    nxt_st.pix_valid = 1'b1;
                    nxt_st.pix_idx   = '0;
                    nxt_st.st        = SRRC_D_READ;
                end
            end
            SRRC_D_READ: begin
                if (st_ff.pix_idx == row_len - 16'h0001) begin
                    nxt_st.pix_valid = 1'b0;
                    nxt_st.st        = SRRC_D_IDLE;
                    // Binned lines leave as one line every 2^n rows
                    if (st_ff.line_cnt >= line_last) begin
                        nxt_st.line_cnt  = '0;
                        nxt_st.line_emit = 1'b1;
                    end else begin
                        nxt_st.line_cnt = st_ff.line_cnt + 2'h1;
                    end
                end else begin
                    nxt_st.pix_idx = st_ff.pix_idx + 16'h0001;
                end
            end
            default: begin
                nxt_st.st = SRRC_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_ff        <= '0;
            st_ff.st     <= SRRC_D_IDLE;
            st_ff.done_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign lnk.sampling_done_n = st_ff.done_n;
    assign o_charge_move       = st_ff.charge_move;
    assign o_cds_busy          = tmr_busy;
    assign o_cds_applied       = st_ff.cds_applied;
    assign o_pixel_valid       = st_ff.pix_valid;
    assign o_pixel_idx         = st_ff.pix_idx;
    assign o_line_emit         = st_ff.line_emit;
    assign o_video_ext         = st_ff.video_ext;
    assign o_mode              = st_ff.mode;
endmodule

`default_nettype wire

// ===== bench/srrc_chk.sv
/*
 * Concurrent checks on the strobes between controller and sensor.
 * Assumes the bench builds the controller with XFER_CYC of 2.
 */
`timescale 1ns/1ps
`default_nettype none

module srrc_chk (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // Link strobes
    input  wire logic row_xfer_n,
    input  wire logic sampling_start_n,
    input  wire logic readout_go_n,
    input  wire logic sampling_done_n
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////
    a_xfer_len: assert property (
        $fell(row_xfer_n) |=> !row_xfer_n ##1 row_xfer_n)
        else $error("row strobe length wrong");
    a_start_one_cycle: assert property (
        $fell(sampling_start_n) |=> sampling_start_n)
        else $error("sampling start longer than one cycle");
    a_done_bound: assert property (
        $fell(sampling_start_n) |-> ##[1:40] !sampling_done_n)
        else $error("sampling done never came");
    a_go_after_done: assert property (
        $fell(sampling_done_n) |=> !readout_go_n)
        else $error("readout go late");
    a_go_one_cycle: assert property (
        $fell(readout_go_n) |=> readout_go_n)
        else $error("readout go longer than one cycle");
    a_done_release: assert property (
        !readout_go_n |=> sampling_done_n)
        else $error("sampling done held after readout go");
    a_start_after_xfer: assert property (
        $fell(sampling_start_n) |-> $rose(row_xfer_n))
        else $error("sampling start not right after row strobe");
    a_start_idle: assert property (
        !sampling_start_n |-> sampling_done_n && readout_go_n)
        else $error("sampling start out of order");
    a_strobes_apart: assert property (
        $onehot0({~row_xfer_n, ~sampling_start_n, ~readout_go_n}))
        else $error("two strobes low together");

    c_xfer: cover property ($fell(row_xfer_n));
    c_start: cover property ($fell(sampling_start_n));
    c_go: cover property ($fell(readout_go_n));
endmodule

`default_nettype wire

// ===== bench/slave_row_readout_control_test.sv
/*
 * Self-checking bench: both ends joined, driven through the register port.
 * Assumes COLS 8 and short timer counts so frames stay brief.
 */
`timescale 1ns/1ps
`default_nettype none

`include "srrc_cfg.svh"

module slave_row_readout_control_test
    import srrc_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr   = 1'b0;
    logic        i_rd   = 1'b0;
    logic [31:0] o_rdata;
    logic        o_busy, o_frame_done;
    logic        cds_ap, pix_v, line_e, vid_ext, chg, cbz;
    logic [15:0] pidx;
    logic [15:0] last_idx = 16'h0000;
    srrc_mode_e  mode_o;
    int          num_errors = 0;
    int          n_compared = 0;
    int          n_pix = 0, n_line = 0, n_raw = 0;
    int          n_chg = 0, n_cbz = 0;

    always #25 i_mclk = ~i_mclk;

    srrc_if lnk_i ();

    srrc_controller #(.COLS(8), .XFER_CYC(2)) srrc_controller_i (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_busy(o_busy), .o_frame_done(o_frame_done), .lnk(lnk_i));

    srrc_sensor #(.COLS(8), .CDS_CYC(2)) srrc_sensor_i (
        .i_mclk(i_mclk), .i_rst(i_rst), .lnk(lnk_i),
        .o_charge_move(chg), .o_cds_busy(cbz), .o_cds_applied(cds_ap),
        .o_pixel_valid(pix_v), .o_pixel_idx(pidx), .o_line_emit(line_e),
        .o_video_ext(vid_ext), .o_mode(mode_o));

    srrc_chk srrc_chk_i (
        .i_mclk(i_mclk), .i_rst(i_rst),
        .row_xfer_n(lnk_i.row_xfer_n),
        .sampling_start_n(lnk_i.sampling_start_n),
        .readout_go_n(lnk_i.readout_go_n),
        .sampling_done_n(lnk_i.sampling_done_n));

    // Pixel path tallies, taken mid-cycle so no edge race with readers
    always @(negedge i_mclk) begin
        n_pix  += int'(pix_v === 1'b1);
        n_line += int'(line_e === 1'b1);
        n_raw  += int'(pix_v === 1'b1 && cds_ap === 1'b0);
        n_chg  += int'(chg === 1'b1);
        n_cbz  += int'(cbz === 1'b1);
        if (pix_v === 1'b1) begin
            last_idx = pidx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Runs one frame; returns pixel and line counts seen
    task automatic frame(input logic [31:0] cfg, input logic [31:0] rows,
                         input logic [31:0] ctl, output int pix,
                         output int lines);
        int p0, l0, k;
        wr(`SRRC_REG_CFG, cfg);
        wr(`SRRC_REG_ROWS, rows);
        p0 = n_pix;
        l0 = n_line;
        wr(`SRRC_REG_CTRL, ctl);
        #1 chk(32'(o_busy), 32'h0000_0001);
        k = 0;
        while (o_frame_done !== 1'b1 && k < 3000) begin
            @(posedge i_mclk);
            #1;
            k++;
        end
        chk(32'(o_frame_done), 32'h0000_0001);
        repeat (2) @(posedge i_mclk);
        pix   = n_pix - p0;
        lines = n_line - l0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [31:0] c;
        int          px, ln;
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(`SRRC_REG_CFG, d);  chk(d, 32'h0000_0000);
        rd(`SRRC_REG_ROWS, d); chk(d, 32'h0000_0400);
        rd(`SRRC_REG_ACC, d);  chk(d, 32'h0000_0008);
        rd(8'h14, d);          chk(d, 32'h0000_0000);
        // Every mode, bin code and both video sources
        for (int m = 0; m < 4; m++) begin
            c = 32'(m) | 32'(m << 2) | 32'(m << 4) | 32'((m & 1) << 6);
            wr(`SRRC_REG_CFG, c);
            repeat (2) @(posedge i_mclk);
            #1;
            chk(32'({lnk_i.readout_mode_hi, lnk_i.readout_mode_lo}), m);
            chk(32'(mode_o), m);
            chk(32'(lnk_i.video_source_sel), m & 1);
            chk(32'(vid_ext), m & 1);
            chk(32'({lnk_i.column_bin_hi, lnk_i.column_bin_lo}), m);
            chk(32'({lnk_i.line_bin_hi, lnk_i.line_bin_lo}), m);
        end
        // A write without GO starts nothing
        wr(`SRRC_REG_CTRL, 32'h0000_0000);
        #1 chk(32'(o_busy), 32'h0000_0000);
        frame(32'h0000_0000, 32'h0000_0002, 32'h0000_0001, px, ln);
        chk(px, 32'h0000_0010);
        chk(ln, 32'h0000_0002);
        chk(n_raw, 32'h0000_0000);
        chk(n_chg, 32'h0000_0004);
        chk(n_cbz, 32'h0000_0004);
        chk(32'(last_idx), 32'h0000_0007);
        frame(32'h0000_0014, 32'h0000_0004, 32'h0000_0001, px, ln);
        chk(px, 32'h0000_0010);
        chk(ln, 32'h0000_0002);
        frame(32'h0000_0028, 32'h0000_0004, 32'h0000_0001, px, ln);
        chk(px, 32'h0000_0008);
        chk(ln, 32'h0000_0001);
        // Accumulate rows then automatic switch to mode one
        wr(`SRRC_REG_ACC, 32'h0000_0002);
        frame(32'h0000_0002, 32'h0000_0004, 32'h0000_0003, px, ln);
        chk(n_raw, 32'h0000_0010);
        chk(32'(n_raw < 32), 32'h0000_0001);
        rd(`SRRC_REG_CFG, d);  chk(d & 32'h0000_0003, 32'h0000_0001);
        rd(`SRRC_REG_STAT, d); chk(d & 32'h0000_0011, 32'h0000_0010);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        conclude();
    end
endmodule

`default_nettype wire
